// ---- hdl/ident_pkg.sv ----
// Contract
// [R01] On the surface the identification squitter repeats with gaps drawn uniformly from 9.6 s to 10.4 s.
// [R02] Airborne the identification squitter repeats with gaps drawn uniformly from 4.8 s to 5.2 s.
// [R03] Either air/ground discrete held at ground puts the block in the surface state.
// [R04] The block is airborne only while neither air/ground discrete is grounded, and the gap range follows.
// [R05] An open category-set discrete selects category set A for the message.
// [R06] A grounded category-set discrete selects category set B for the message.
// [R07] Category bits 2 and 0 grounded with bit 1 open report category 5, a grounded pin counting as one.
// [R08] Category bit 1 grounded with bits 2 and 0 open report category 2.
// [R09] The message goes out as a format 17 extended squitter carrying the category and the characters.
// [R10] Every transmission draws a fresh gap and repeats the same content while the inputs hold.
// [R11] The feeding equipment refreshes each identification parameter at least once per second.
// [R12] A zero or missing ground speed is taken as consistent with surface operation at the surface rate.
// [R13] Gaps come from a free-running pseudo-random generator at one millisecond resolution.
// [R14] Discretes are filtered against bounce and a change takes effect by the next transmission.
package ident_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
   localparam logic [16:0] MS_CNT_ZERO = 17'h00000;

   // gap limits in milliseconds
   localparam logic [13:0] SURF_MIN_MS = 14'h2580;
   localparam logic [13:0] SURF_MAX_MS = 14'h28A0;
   localparam logic [13:0] AIR_MIN_MS = 14'h12C0;
   localparam logic [13:0] AIR_MAX_MS = 14'h1450;
   localparam logic [9:0] SURF_SPAN_MS = 10'h320;
   localparam logic [9:0] AIR_SPAN_MS = 10'h190;
   localparam logic [9:0] AIR_DRAW_MASK = 10'h1FF;
   localparam logic [13:0] WAIT_ZERO = 14'h0000;

   localparam logic [10:0] ID_REFRESH_MS = 11'h3E8;
   localparam logic [2:0] DEBOUNCE_MS = 3'h4;

   localparam logic [4:0] DF_EXT_SQUITTER = 5'h11;
   localparam logic [4:0] TC_SET_A = 5'h04;
   localparam logic [4:0] TC_SET_B = 5'h03;

   localparam logic [31:0] LFSR_SEED = 32'h00000001;
   localparam logic [31:0] LFSR_TAPS = 32'h80200003;

   // discretes are ground-active: 0 means grounded
   typedef struct packed {
      logic air_gnd1_n;
      logic air_gnd2_n;
      logic cat_set_n;
      logic [2:0] cat_n;
   } disc_t;
   localparam logic [5:0] DISC_OPEN = 6'h3F;

   typedef struct packed {
      logic [4:0] tc;
      logic [2:0] cat;
      logic [47:0] chars;
   } ident_me_t;

   typedef struct packed {
      logic [4:0] df;
      logic [2:0] ca;
      logic [23:0] aa;
      ident_me_t me;
   } squitter_t;

   typedef enum logic [2:0] {
      ST_DRAW = 3'b001,
      ST_WAIT = 3'b010,
      ST_SEND = 3'b100
   } sched_state_t;
endpackage : ident_pkg

// ---- hdl/discrete_filter.sv ----
`timescale 1ns/100ps
module discrete_filter #(
   parameter int W = 6,
   parameter logic [W-1:0] RST_VAL = '1,
   parameter logic [2:0] STABLE = 3'h4
) (
   // clock and control
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic tick,
   // pins in, filtered out
   input wire logic [W-1:0] raw,
   output logic [W-1:0] filt
);
   logic [W-1:0] cand_reg, cand_next, filt_reg, filt_next;
   logic [2:0] cnt_reg, cnt_next;

   // any change restarts the count, so a bouncing contact never passes
   always_comb begin
      cand_next = raw;
      cnt_next = cnt_reg;
      filt_next = filt_reg;
      if (raw != cand_reg) begin
         cnt_next = 3'h0;
      end else if (tick && cnt_reg != STABLE) begin
         cnt_next = cnt_reg + 3'h1;
      end
      if (cnt_reg == STABLE) begin
         filt_next = cand_reg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cand_reg <= RST_VAL;
         cnt_reg <= 3'h0;
         filt_reg <= RST_VAL;
      end else if (ce) begin
         cand_reg <= cand_next;
         cnt_reg <= cnt_next;
         filt_reg <= filt_next;
      end
   end

   assign filt = filt_reg;
endmodule : discrete_filter

// ---- hdl/ident_squitter_scheduler.sv ----
`timescale 1ns/100ps
module ident_squitter_scheduler
   import ident_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ce,
   // discrete pins
   input wire disc_t disc_pins,
   // ground speed
   input wire logic [15:0] gnd_speed,
   input wire logic gnd_speed_valid,
   // identification data
   input wire logic [47:0] id_chars,
   input wire logic id_load,
   input wire logic [23:0] icao_addr,
   input wire logic [2:0] capability,
   // squitter out
   output squitter_t sq_frame,
   output logic sq_strobe,
   // status
   output logic surface_state,
   output logic gs_consistent,
   output logic id_stale
);
   localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

   disc_t flt;
   logic [5:0] flt_bits;

   logic [16:0] ms_cnt_reg, ms_cnt_next;
   logic tick_reg, tick_next;
   logic [31:0] lfsr_reg, lfsr_next;
   sched_state_t state_reg, state_next;
   logic [13:0] wait_reg, wait_next;
   logic surface_reg, surface_next;
   logic gs_ok_reg, gs_ok_next;
   logic [47:0] chars_reg, chars_next;
   logic [10:0] age_reg, age_next;
   logic stale_reg, stale_next;
   squitter_t frame_reg, frame_next;
   logic strobe_reg, strobe_next;
   logic [9:0] draw;
   logic draw_ok;

   discrete_filter #(
      .W(6),
      .RST_VAL(DISC_OPEN),
      .STABLE(DEBOUNCE_MS)
   ) u_filter (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .tick(tick_reg),
      .raw(disc_pins),
      .filt(flt_bits)
   );  // R14
   assign flt = disc_t'(flt_bits);

   // millisecond tick and free-running generator
   always_comb begin
      ms_cnt_next = ms_cnt_reg + 17'h00001;
      tick_next = 1'b0;
      if (ms_cnt_reg == MS_LAST) begin
         ms_cnt_next = MS_CNT_ZERO;
         tick_next = 1'b1;
      end
      // galois shift every cycle, so the draw depends on event timing too
      lfsr_next = {1'b0, lfsr_reg[31:1]} ^ (lfsr_reg[0] ? LFSR_TAPS : 32'h00000000);  // R13
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ms_cnt_reg <= MS_CNT_ZERO;
         tick_reg <= 1'b0;
         lfsr_reg <= LFSR_SEED;
      end else if (ce) begin
         ms_cnt_reg <= ms_cnt_next;
         tick_reg <= tick_next;
         lfsr_reg <= lfsr_next;
      end
   end

   // air/ground state and identification data
   always_comb begin
      surface_next = !flt.air_gnd1_n || !flt.air_gnd2_n;  // R03 R04
      // zero or missing speed never vetoes the surface rate
      gs_ok_next = surface_next && (!gnd_speed_valid || gnd_speed == 16'h0000);  // R12
      chars_next = id_load ? id_chars : chars_reg;
      age_next = age_reg;
      if (id_load) begin
         age_next = 11'h000;
      end else if (tick_reg && age_reg != ID_REFRESH_MS) begin
         age_next = age_reg + 11'h001;
      end
      // stale flags a feeder that misses its once-a-second refresh
      stale_next = (age_reg == ID_REFRESH_MS) && !id_load;  // R11
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         surface_reg <= 1'b1;
         gs_ok_reg <= 1'b0;
         chars_reg <= 48'h000000000000;
         age_reg <= ID_REFRESH_MS;
         stale_reg <= 1'b1;
      end else if (ce) begin
         surface_reg <= surface_next;
         gs_ok_reg <= gs_ok_next;
         chars_reg <= chars_next;
         age_reg <= age_next;
         stale_reg <= stale_next;
      end
   end

   // draws beyond the span are thrown away and redrawn; modulo would skew
   assign draw = surface_reg ? lfsr_reg[9:0] : (lfsr_reg[9:0] & AIR_DRAW_MASK);
   assign draw_ok = surface_reg ? (draw <= SURF_SPAN_MS) : (draw <= AIR_SPAN_MS);

   // scheduler
   always_comb begin
      state_next = state_reg;
      wait_next = wait_reg;
      frame_next = frame_reg;
      strobe_next = 1'b0;
      unique case (state_reg)
         ST_DRAW: begin
            if (draw_ok) begin
               // fresh gap per transmission, range from the current state
               if (surface_reg) begin
                  wait_next = SURF_MIN_MS + {4'h0, draw};  // R01 R10
               end else begin
                  wait_next = AIR_MIN_MS + {4'h0, draw};  // R02 R10
               end
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (wait_reg == WAIT_ZERO) begin
               state_next = ST_SEND;
            end else if (tick_reg) begin
               wait_next = wait_reg - 14'h0001;
            end
         end
         ST_SEND: begin
            // content rebuilt from filtered discretes, raw capability and address, and stored characters, so it repeats while they hold
            frame_next.df = DF_EXT_SQUITTER;  // R09
            frame_next.ca = capability;
            frame_next.aa = icao_addr;
            frame_next.me.tc = flt.cat_set_n ? TC_SET_A : TC_SET_B;  // R05 R06
            frame_next.me.cat = ~flt.cat_n;  // R07 R08
            frame_next.me.chars = chars_reg;  // R09
            strobe_next = 1'b1;
            state_next = ST_DRAW;
         end
         default: begin
            state_next = ST_DRAW;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_reg <= ST_DRAW;
         wait_reg <= WAIT_ZERO;
         frame_reg <= '0;
         strobe_reg <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         wait_reg <= wait_next;
         frame_reg <= frame_next;
         strobe_reg <= strobe_next;
      end
   end

   assign sq_frame = frame_reg;
   assign sq_strobe = strobe_reg;
   assign surface_state = surface_reg;
   assign gs_consistent = gs_ok_reg;
   assign id_stale = stale_reg;

   property p_surf_gap;
      @(posedge ref_clk) disable iff (sys_rst)
      (ce && state_reg == ST_DRAW && draw_ok && surface_reg)
         |=> (wait_reg >= SURF_MIN_MS && wait_reg <= SURF_MAX_MS && state_reg == ST_WAIT);
   endproperty
   a_surf_gap: assert property (p_surf_gap) else $error("surface gap out of range");  // R01

   property p_air_gap;
      @(posedge ref_clk) disable iff (sys_rst)
      (ce && state_reg == ST_DRAW && draw_ok && !surface_reg)
         |=> (wait_reg >= AIR_MIN_MS && wait_reg <= AIR_MAX_MS);
   endproperty
   a_air_gap: assert property (p_air_gap) else $error("airborne gap out of range");  // R02

   property p_ground_disc;
      @(posedge ref_clk) disable iff (sys_rst)
      (ce && (!flt.air_gnd1_n || !flt.air_gnd2_n)) |=> surface_reg;
   endproperty
   a_ground_disc: assert property (p_ground_disc) else $error("grounded discrete not surface");  // R03

   property p_air_disc;
      @(posedge ref_clk) disable iff (sys_rst)
      (ce && flt.air_gnd1_n && flt.air_gnd2_n) |=> !surface_reg;
   endproperty
   a_air_disc: assert property (p_air_disc) else $error("open discretes not airborne");  // R04

   property p_set_a;
      @(posedge ref_clk) disable iff (sys_rst)
      (ce && state_reg == ST_SEND && flt.cat_set_n) |=> (sq_strobe && sq_frame.me.tc == TC_SET_A);
   endproperty
   a_set_a: assert property (p_set_a) else $error("set A not encoded");  // R05

   property p_set_b;
      @(posedge ref_clk) disable iff (sys_rst)
      (ce && state_reg == ST_SEND && !flt.cat_set_n) |=> (sq_frame.me.tc == TC_SET_B);
   endproperty
   a_set_b: assert property (p_set_b) else $error("set B not encoded");  // R06

   property p_cat5;
      @(posedge ref_clk) disable iff (sys_rst)
      (ce && state_reg == ST_SEND && flt.cat_n == 3'h2) |=> (sq_frame.me.cat == 3'h5);
   endproperty
   a_cat5: assert property (p_cat5) else $error("category 5 wrong");  // R07

   property p_cat2;
      @(posedge ref_clk) disable iff (sys_rst)
      (ce && state_reg == ST_SEND && flt.cat_n == 3'h5) |=> (sq_frame.me.cat == 3'h2);
   endproperty
   a_cat2: assert property (p_cat2) else $error("category 2 wrong");  // R08

   property p_df17;
      @(posedge ref_clk) disable iff (sys_rst)
      // first strobe cycle only: a held strobe under low enable would see later data
      $rose(sq_strobe) |-> (sq_frame.df == DF_EXT_SQUITTER && sq_frame.me.chars == $past(chars_reg));
   endproperty
   a_df17: assert property (p_df17) else $error("squitter format wrong");  // R09

   property p_redraw;
      @(posedge ref_clk) disable iff (sys_rst)
      (ce && sq_strobe) |-> (state_reg == ST_DRAW) ##1 !sq_strobe;
   endproperty
   a_redraw: assert property (p_redraw) else $error("no fresh draw after send");  // R10

   property p_lfsr_live;
      @(posedge ref_clk) disable iff (sys_rst)
      ce |=> (lfsr_reg != 32'h00000000 && lfsr_reg != $past(lfsr_reg));
   endproperty
   a_lfsr_live: assert property (p_lfsr_live) else $error("generator stuck");  // R13
endmodule : ident_squitter_scheduler

// ---- test/sq_far_side.sv ----
`timescale 1ns/100ps
module sq_far_side
   import ident_pkg::*;
#(
   parameter int unsigned MSC = 2
) (
   // clock
   input wire logic ref_clk,
   // squitters heard
   input wire squitter_t sq_frame,
   input wire logic sq_strobe,
   output int heard,
   // identification feed
   input wire logic feed_en,
   input wire logic [47:0] feed_val,
   output logic [47:0] id_chars,
   output logic id_load
);
   int cnt = 0;
   initial begin
      id_chars = 48'h000000000000;
      id_load = 1'b0;
      heard = 0;
   end
   // data lines toggle between loads so a stale value never looks valid
   always @(negedge ref_clk) begin
      id_load <= 1'b0;
      id_chars <= ~id_chars;
      cnt <= cnt + 1;
      if (feed_en && cnt >= 500 * MSC) begin
         cnt <= 0;
         id_load <= 1'b1;
         id_chars <= feed_val;
      end
   end
   always @(posedge ref_clk) begin
      if (sq_strobe === 1'b1 && sq_frame.df === DF_EXT_SQUITTER) heard <= heard + 1;
   end
endmodule : sq_far_side

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   import ident_pkg::*;
   localparam int unsigned MSC = 2;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   disc_t disc_pins = DISC_OPEN;
   logic [15:0] gnd_speed = 16'h0000;
   logic gnd_speed_valid = 1'b0;
   logic [47:0] id_chars;
   logic id_load;
   logic [23:0] icao_addr = 24'h000000;
   logic [2:0] capability = 3'h0;
   squitter_t sq_frame;
   logic sq_strobe, surface_state, gs_consistent, id_stale;
   logic feed_en = 1'b1;
   logic [47:0] feed_val = 48'h000000000000;
   logic [2:0] exp_cat = 3'h0;
   logic [47:0] m_chars = 48'h000000000000;
   logic [47:0] m_chars_d = 48'h000000000000;
   logic surf_at = 1'b0;
   int seed = 32'hFE2E00C8;
   int miscompares = 0;
   int total_checks = 0;
   int frames = 0;
   int heard, gap, lo, hi;
   int gmin = 0;
   int gmax = 0;
   int gaps[$];
   longint cyc = 0;
   longint last_t = 0;

   ident_squitter_scheduler #(.MS_CYCLES(MSC)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .ce(ce), .disc_pins(disc_pins), .gnd_speed(gnd_speed), .gnd_speed_valid(gnd_speed_valid),
      .id_chars(id_chars), .id_load(id_load), .icao_addr(icao_addr), .capability(capability),
      .sq_frame(sq_frame), .sq_strobe(sq_strobe), .surface_state(surface_state),
      .gs_consistent(gs_consistent), .id_stale(id_stale));
   sq_far_side #(.MSC(MSC)) u_far (.ref_clk(ref_clk), .sq_frame(sq_frame),
      .sq_strobe(sq_strobe), .heard(heard), .feed_en(feed_en), .feed_val(feed_val),
      .id_chars(id_chars), .id_load(id_load));

   always #5 ref_clk = ~ref_clk;

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic wait_frames(input int n);
      int k, lim;
      k = frames + n;
      lim = 0;
      while (frames < k && lim < n * 11000 * MSC) begin
         @(negedge ref_clk);
         lim++;
      end
      if (frames < k) begin
         miscompares++;
         tally_and_finish();
      end
   endtask : wait_frames

   task automatic settle;
      repeat (6 * MSC + 4) @(negedge ref_clk);
   endtask : settle

   // reference copy of the stored characters, one edge behind for send alignment
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      m_chars_d <= m_chars;
      if (!sys_rst && ce && id_load === 1'b1) m_chars <= id_chars;
   end

   always @(negedge ref_clk) begin
      if (!sys_rst && sq_strobe === 1'b1) begin
         check(sq_frame.df, DF_EXT_SQUITTER);
         check(sq_frame.ca, capability);
         check(sq_frame.aa, icao_addr);
         check(sq_frame.me.tc, disc_pins.cat_set_n ? TC_SET_A : TC_SET_B);
         check(sq_frame.me.cat, exp_cat);
         check(sq_frame.me.chars, m_chars_d);
         if (frames > 0) begin
            gap = int'(cyc - last_t);
            gaps.push_back(gap);
            if (gaps.size() == 1 || gap < gmin) gmin = gap;
            if (gaps.size() == 1 || gap > gmax) gmax = gap;
            lo = int'(surf_at ? SURF_MIN_MS : AIR_MIN_MS) * MSC - MSC;
            hi = int'(surf_at ? SURF_MAX_MS : AIR_MAX_MS) * MSC + MSC + 64;
            check(gap >= lo && gap <= hi, 1'b1);
         end
         last_t = cyc;
         surf_at = surface_state;
         frames++;
      end
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      sys_rst = 1'b0;
      icao_addr = 24'($random(seed));
      capability = 3'($random(seed));
      feed_val = {16'($random(seed)), 32'($random(seed))};
      // airborne, set A, category 5
      disc_pins = {1'b1, 1'b1, 1'b1, 3'b010};
      exp_cat = 3'h5;
      settle();
      check(surface_state, 1'b0);
      check(gs_consistent, 1'b0);
      // short ground glitch must not pass the filter
      disc_pins.air_gnd1_n = 1'b0;
      repeat (2 * MSC) @(negedge ref_clk);
      disc_pins.air_gnd1_n = 1'b1;
      settle();
      check(surface_state, 1'b0);
      wait_frames(3);
      // one discrete grounded, set B, category 2, speed zero
      feed_val = {16'($random(seed)), 32'($random(seed))};
      disc_pins = {1'b1, 1'b0, 1'b0, 3'b101};
      exp_cat = 3'h2;
      gnd_speed_valid = 1'b1;
      settle();
      check(surface_state, 1'b1);
      check(gs_consistent, 1'b1);
      gnd_speed = 16'($random(seed)) | 16'h0001;
      repeat (3) @(negedge ref_clk);
      check(gs_consistent, 1'b0);
      gnd_speed_valid = 1'b0;
      repeat (3) @(negedge ref_clk);
      check(gs_consistent, 1'b1);
      // enable low freezes status while the speed input moves
      ce = 1'b0;
      gnd_speed_valid = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(gs_consistent, 1'b1);
      ce = 1'b1;
      repeat (3) @(negedge ref_clk);
      check(gs_consistent, 1'b0);
      gnd_speed_valid = 1'b0;
      wait_frames(2);
      disc_pins = {1'b0, 1'b1, 1'b0, 3'b101};
      settle();
      check(surface_state, 1'b1);
      // feed stops: data ages out, then recovers on the next load
      feed_en = 1'b0;
      repeat (1000 * MSC + 1200) @(negedge ref_clk);
      check(id_stale, 1'b1);
      feed_en = 1'b1;
      repeat (600 * MSC) @(negedge ref_clk);
      check(id_stale, 1'b0);
      check(gaps.size() >= 3 && gmax != gmin, 1'b1);
      check(heard, frames);
      tally_and_finish();
   end
endmodule : tb_top
